/* flash_host_pkg.sv */
// constants, pin bundle and command types for the sector flash host
// assumes one 200 MHz clock; pin timings use the slowest device grade
package flash_host_pkg;

    // =========================================================
    // clock and pin timing
    localparam int CLK_NS = 5;
    localparam int AS_NS = 10;
    localparam int WP_NS = 200;
    localparam int WPH_NS = 200;
    localparam int DH_NS = 10;
    localparam int ACC_NS = 250;
    localparam int OEHP_NS = 150;
    localparam int DF_NS = 60;
    localparam int BLC_US = 150;
    localparam int WC_MS = 20;
    localparam int SYNC_STAGES = 2;

    // least times round up
    localparam int AS_CYC = (AS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int DH_CYC = (DH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RHIGH_NS = (OEHP_NS > DF_NS) ? OEHP_NS : DF_NS;
    localparam int RHIGH_CYC = (RHIGH_NS + CLK_NS - 1) / CLK_NS;
    // longest time rounds down
    localparam int BLC_CYC = (BLC_US * 1000) / CLK_NS;
    localparam int WC_CYC = (WC_MS * 1000000) / CLK_NS;

    // =========================================================
    // geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SECTOR_BYTES = 64;
    localparam int OFS_W = 6;
    localparam int SEQ_LEN = 3;
    localparam int TOGGLE_BIT = 6;
    localparam int PH_W = 8;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_ID_ENTRY,
        OP_ID_EXIT
    } op_e;

    typedef struct packed {
        op_e op;
        logic [ADDR_W-1:0] addr;
    } cmd_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
    } pins_s;

    localparam pins_s BUS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000, dq: 8'h00, dq_oe: 1'b0};

endpackage

/* flash_write_host.sv */
// host controller that drives a byte-wide sector flash over its pins
// assumes flash data pins come back asynchronously on dq_in; the bench
// resolves the shared data wire from flash_out.dq and flash_out.dq_oe
//
// Functional notes
// (RULE1) sector address on upper lines at every byte-load write strobe fall
// (RULE2) all 64 bytes of a sector loaded in one operation
// (RULE3) unloaded sector bytes become undefined after programming
// (RULE4) device re-protects after each program; each write resends the code
// (RULE5) next byte load starts within 150 us of the previous one
// (RULE6) toggling output or chip enable during programming flips the toggle bit
// (RULE7) toggle bit start/end value undefined; only alternation means busy
// (RULE8) toggle polling may use any address, but it stays constant
// (RULE9) in id mode, id select low gives maker code, high gives part code
// (RULE10) id mode does not survive power loss
// (RULE11) exit sequence returns device to normal reads and programming
// (RULE12) output enable high while writing; protection code precedes sector data
// (RULE13) polling bit reads complement of last data until programming ends
module flash_write_host #(
    parameter logic [44:0] PROT_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [23:0] PROT_DATA = {8'h03, 8'h02, 8'h01},
    parameter logic [44:0] ID_ENTRY_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [23:0] ID_ENTRY_DATA = {8'h13, 8'h12, 8'h11},
    parameter logic [44:0] ID_EXIT_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [23:0] ID_EXIT_DATA = {8'h23, 8'h22, 8'h21},
    parameter int unsigned BLC_LIMIT = flash_host_pkg::BLC_CYC,
    parameter int unsigned WC_LIMIT = flash_host_pkg::WC_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire flash_host_pkg::cmd_s cmd_in,
    output logic cmd_ready_out,
    input wire logic wdat_valid_in,
    input wire logic [7:0] wdat_in,
    output logic wdat_ready_out,
    output logic rsp_valid_out,
    output logic [7:0] rsp_data_out,
    output logic done_out,
    output logic err_out,
    output flash_host_pkg::pins_s flash_out,
    input wire logic [7:0] dq_in
);

    // =========================================================
    // state
    typedef enum {S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_NEXT, S_LWAIT, S_RSET, S_RHIGH} state_e;

    localparam int SEQ_LAST = flash_host_pkg::SEQ_LEN - 1;
    localparam int SEC_LAST = flash_host_pkg::SECTOR_BYTES - 1;

    state_e state_r;
    flash_host_pkg::cmd_s cmd_r;
    flash_host_pkg::pins_s pins_r;
    logic [1:0] code_idx_r;
    logic in_code_r;
    logic [5:0] byte_idx_r;
    logic polling_r;
    logic have_prev_r;
    logic prev_tog_r;
    logic [7:0] rd_r;
    logic [flash_host_pkg::PH_W-1:0] cnt_r;
    logic [31:0] blc_cnt_r;
    logic [31:0] prog_cnt_r;
    logic [7:0] dq_s1_r;
    logic [7:0] dq_s2_r;

    // =========================================================
    // helpers
    function automatic logic [14:0] seq_addr(input flash_host_pkg::op_e op, input logic [1:0] idx);
        case (op)
            flash_host_pkg::OP_ID_ENTRY: seq_addr = ID_ENTRY_ADDR[idx*15 +: 15];
            flash_host_pkg::OP_ID_EXIT: seq_addr = ID_EXIT_ADDR[idx*15 +: 15];
            default: seq_addr = PROT_ADDR[idx*15 +: 15];
        endcase
    endfunction

    function automatic logic [7:0] seq_data(input flash_host_pkg::op_e op, input logic [1:0] idx);
        case (op)
            flash_host_pkg::OP_ID_ENTRY: seq_data = ID_ENTRY_DATA[idx*8 +: 8];
            flash_host_pkg::OP_ID_EXIT: seq_data = ID_EXIT_DATA[idx*8 +: 8];
            default: seq_data = PROT_DATA[idx*8 +: 8];
        endcase
    endfunction

    // oe stays high for the whole write cycle
    function automatic flash_host_pkg::pins_s bus_write(input logic [14:0] a, input logic [7:0] d);
        bus_write = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, addr: a, dq: d, dq_oe: 1'b1}; // RULE12
    endfunction

    function automatic flash_host_pkg::pins_s bus_read(input logic [14:0] a);
        bus_read = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, dq: 8'h00, dq_oe: 1'b0};
    endfunction

    // polling reads byte 0 of the sector being programmed, never moved
    function automatic logic [14:0] poll_addr(input logic [14:0] a);
        poll_addr = {a[14:6], 6'h00}; // RULE8
    endfunction

    assign cmd_ready_out = (state_r == S_IDLE);
    assign wdat_ready_out = (state_r == S_LWAIT);
    assign flash_out = pins_r;

    // =========================================================
    // data pin synchroniser
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
        end else begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
        end
    end

    // =========================================================
    // watchdogs for byte gap and program cycle
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            blc_cnt_r <= 32'h0000_0000;
        end else if (state_r == S_LWAIT) begin
            blc_cnt_r <= blc_cnt_r + 32'h0000_0001; // RULE5
        end else begin
            blc_cnt_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            prog_cnt_r <= 32'h0000_0000;
        end else if (polling_r) begin
            prog_cnt_r <= prog_cnt_r + 32'h0000_0001;
        end else begin
            prog_cnt_r <= 32'h0000_0000;
        end
    end

    // =========================================================
    // sequencer
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_r <= S_IDLE;
            cmd_r <= '0;
            pins_r <= flash_host_pkg::BUS_IDLE;
            code_idx_r <= 2'h0;
            in_code_r <= 1'b0;
            byte_idx_r <= 6'h00;
            polling_r <= 1'b0;
            have_prev_r <= 1'b0;
            prev_tog_r <= 1'b0;
            rd_r <= 8'h00;
            cnt_r <= '0;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 8'h00;
            done_out <= 1'b0;
            err_out <= 1'b0;
        end else begin
            rsp_valid_out <= 1'b0;
            done_out <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    pins_r <= flash_host_pkg::BUS_IDLE;
                    cnt_r <= '0;
                    if (cmd_valid_in) begin
                        cmd_r <= cmd_in;
                        err_out <= 1'b0;
                        polling_r <= 1'b0;
                        if (cmd_in.op == flash_host_pkg::OP_READ) begin
                            // id codes come back on plain reads at 0 and 1 while id mode is on
                            pins_r <= bus_read(cmd_in.addr); // RULE9
                            state_r <= S_RSET;
                        end else begin
                            // every sector write is preceded by the protection code
                            in_code_r <= 1'b1; // RULE4 RULE11
                            code_idx_r <= 2'h0;
                            pins_r <= bus_write(seq_addr(cmd_in.op, 2'h0), seq_data(cmd_in.op, 2'h0));
                            state_r <= S_WSET;
                        end
                    end
                end
                S_WSET: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::AS_CYC - 1)) begin
                        pins_r.we_n <= 1'b0;
                        cnt_r <= '0;
                        state_r <= S_WLOW;
                    end
                end
                S_WLOW: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::WP_CYC - 1)) begin
                        pins_r.we_n <= 1'b1;
                        cnt_r <= '0;
                        state_r <= S_WHIGH;
                    end
                end
                S_WHIGH: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::DH_CYC - 1)) begin
                        pins_r.dq_oe <= 1'b0;
                        pins_r.ce_n <= 1'b1;
                    end
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::WPH_CYC - 1)) begin
                        cnt_r <= '0;
                        state_r <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    if (in_code_r) begin
                        if (code_idx_r == 2'(SEQ_LAST)) begin
                            in_code_r <= 1'b0;
                            if (cmd_r.op == flash_host_pkg::OP_WRITE) begin
                                byte_idx_r <= 6'h00;
                                state_r <= S_LWAIT; // RULE12
                            end else begin
                                done_out <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end else begin
                            code_idx_r <= code_idx_r + 2'h1;
                            pins_r <= bus_write(seq_addr(cmd_r.op, code_idx_r + 2'h1),
                                                seq_data(cmd_r.op, code_idx_r + 2'h1));
                            state_r <= S_WSET;
                        end
                    end else if (byte_idx_r == 6'(SEC_LAST)) begin
                        // full sector sent; the device now erases and programs
                        polling_r <= 1'b1; // RULE2
                        have_prev_r <= 1'b0;
                        pins_r <= bus_read(poll_addr(cmd_r.addr));
                        state_r <= S_RSET;
                    end else begin
                        byte_idx_r <= byte_idx_r + 6'h01;
                        state_r <= S_LWAIT;
                    end
                end
                S_LWAIT: begin
                    if (wdat_valid_in) begin
                        pins_r <= bus_write({cmd_r.addr[14:6], byte_idx_r}, wdat_in); // RULE1
                        state_r <= S_WSET;
                    end else if (blc_cnt_r >= BLC_LIMIT - 1) begin
                        // source too slow: device starts programming a partial sector
                        err_out <= 1'b1; // RULE3 RULE5
                        polling_r <= 1'b1;
                        have_prev_r <= 1'b0;
                        pins_r <= bus_read(poll_addr(cmd_r.addr));
                        state_r <= S_RSET;
                    end
                end
                S_RSET: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::ACC_CYC + flash_host_pkg::SYNC_STAGES - 1)) begin
                        rd_r <= dq_s2_r;
                        // both strobes rise between polls so the toggle bit advances
                        pins_r.oe_n <= 1'b1; // RULE6
                        pins_r.ce_n <= 1'b1;
                        cnt_r <= '0;
                        state_r <= S_RHIGH;
                    end
                end
                S_RHIGH: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == flash_host_pkg::PH_W'(flash_host_pkg::RHIGH_CYC - 1)) begin
                        cnt_r <= '0;
                        if (!polling_r) begin
                            rsp_valid_out <= 1'b1;
                            rsp_data_out <= rd_r;
                            done_out <= 1'b1;
                            state_r <= S_IDLE;
                        end else if (have_prev_r && (prev_tog_r == rd_r[flash_host_pkg::TOGGLE_BIT])) begin
                            // two equal toggle samples: program over, protection back on
                            polling_r <= 1'b0; // RULE7 RULE4
                            done_out <= 1'b1;
                            state_r <= S_IDLE;
                        end else if (prog_cnt_r >= WC_LIMIT) begin
                            err_out <= 1'b1;
                            polling_r <= 1'b0;
                            done_out <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            // first sample value is meaningless, only kept for compare
                            prev_tog_r <= rd_r[flash_host_pkg::TOGGLE_BIT]; // RULE7
                            have_prev_r <= 1'b1;
                            pins_r <= bus_read(poll_addr(cmd_r.addr)); // RULE8
                            state_r <= S_RSET;
                        end
                    end
                end
                default: begin
                    pins_r <= flash_host_pkg::BUS_IDLE;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule

/* flash_write_host_props.sv */
// assertions on the sector flash host ports
// assumes a bind onto flash_write_host; one clock, synchronous low reset
module flash_write_host_props #(
    parameter int unsigned BLC_LIMIT = 30000
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire flash_host_pkg::cmd_s cmd_in,
    input wire logic cmd_ready_out,
    input wire logic wdat_valid_in,
    input wire logic [7:0] wdat_in,
    input wire logic wdat_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [7:0] rsp_data_out,
    input wire logic done_out,
    input wire logic err_out,
    input wire flash_host_pkg::pins_s flash_out,
    input wire logic [7:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================
    // command tracking
    logic we_d_r;
    logic wr_r;
    logic [8:0] sect_r;
    logic [6:0] nb_r;
    logic [3:0] falls_r;
    int unsigned gap_r;
    wire take = wdat_valid_in && wdat_ready_out;
    wire we_fall = we_d_r && !flash_out.we_n;
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            we_d_r <= 1'b1;
            wr_r <= 1'b0;
            nb_r <= 7'h00;
            falls_r <= 4'h0;
            gap_r <= 0;
        end else begin
            we_d_r <= flash_out.we_n;
            gap_r <= (wdat_ready_out && !wdat_valid_in) ? gap_r + 1 : 0;
            if (cmd_valid_in && cmd_ready_out) begin
                wr_r <= cmd_in.op == flash_host_pkg::OP_WRITE;
                sect_r <= cmd_in.addr[14:6];
                nb_r <= 7'h00;
                falls_r <= 4'h0;
            end else begin
                nb_r <= nb_r + 7'(take);
                // saturate: only the first three falls are the code
                falls_r <= falls_r + 4'(we_fall && falls_r != 4'hF);
            end
        end
    end
    // =====================================
    // properties
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_strobe_low;
        (flash_out.dq_oe && flash_out.oe_n) throughout (!flash_out.we_n [*8]);
    endsequence
    a_oe_high_write: assert property (!flash_out.we_n && !flash_out.ce_n |-> flash_out.oe_n)
        else $error("output enable low while writing");
    a_write_strobe: assert property (we_fall |-> s_strobe_low)
        else $error("write pulse short or data not driven");
    a_no_bus_fight: assert property (!flash_out.oe_n |-> !flash_out.dq_oe)
        else $error("host drives data during a read");
    a_sector_addr: assert property (wr_r && falls_r >= 4'h3 && we_fall |-> flash_out.addr == {sect_r, 6'(nb_r - 7'h01)})
        else $error("byte load outside the sector");
    a_code_first: assert property (wr_r && take && nb_r == 7'h00 |-> falls_r == 4'h3)
        else $error("sector data before the protection code");
    a_byte_limit: assert property (wdat_ready_out |-> nb_r < 7'd64)
        else $error("more than one sector of bytes asked");
    a_full_sector: assert property (done_out && wr_r && !err_out |-> nb_r == 7'd64)
        else $error("write ended clean with a partial sector");
    a_byte_gap: assert property (gap_r <= BLC_LIMIT + 2)
        else $error("byte load gap beyond limit");
    a_gap_err: assert property ($fell(wdat_ready_out) && gap_r != 0 |-> ##[0:3] err_out)
        else $error("gap timeout not flagged");
    a_poll_addr: assert property (wr_r && (nb_r == 7'd64 || err_out) && $fell(flash_out.oe_n) |->
        flash_out.addr == {sect_r, 6'h00})
        else $error("status poll address moved");
endmodule

/* flash_dev_model.sv */
// behavioural sector flash device on the host pins
// assumes pins move on the host clock; code bytes match the host defaults
module flash_dev_model #(
    parameter int BLC = 150,
    parameter int PROG = 600,
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_ID = 8'hC3 // arbitrary value
) (
    input wire logic clk_in,
    input wire logic pwr_n_in,
    input wire flash_host_pkg::pins_s pins_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:32767];
    logic [7:0] buf_r [0:63];
    logic [63:0] ld_r;
    logic [7:0] last_r;
    logic [14:0] wa_r;
    logic [8:0] sect_r;
    logic [45:0] sh_r;
    logic load_r, id_r, busy_r, tog_r, rd_d_r, we_d_r;
    int cnt_r;
    wire rd = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n;
    wire we_rise = !we_d_r && pins_in.we_n && !pins_in.ce_n;
    initial for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    assign dq_oe_out = rd;
    assign dq_out = busy_r ? {~last_r[7], tog_r, last_r[5:0]} :
        (id_r && pins_in.addr[14:1] == 14'h0000) ? (pins_in.addr[0] ? PART_ID : MAKER_ID) : mem[pins_in.addr];
    always @(posedge clk_in) begin
        we_d_r <= pins_in.we_n;
        rd_d_r <= rd;
        cnt_r <= cnt_r + 1;
        if (we_d_r && !pins_in.we_n) wa_r <= pins_in.addr;
        if (rd && !rd_d_r) tog_r <= ~tog_r;
        if (busy_r && cnt_r >= PROG) begin
            busy_r <= 1'b0;
            for (int i = 0; i < 64; i++) mem[{sect_r, 6'(i)}] <= ld_r[i] ? buf_r[i] : 8'hXX;
        end
        if (load_r && (cnt_r >= BLC || &ld_r)) begin
            load_r <= 1'b0;
            busy_r <= 1'b1;
            cnt_r <= 0;
        end
        if (we_rise && load_r) begin
            buf_r[wa_r[5:0]] <= pins_in.dq;
            ld_r[wa_r[5:0]] <= 1'b1;
            sect_r <= wa_r[14:6];
            last_r <= pins_in.dq;
            cnt_r <= 0;
        end else if (we_rise && !busy_r) begin
            // writes outside a full code sequence are ignored
            sh_r <= {sh_r[22:0], wa_r, pins_in.dq};
            case ({sh_r, wa_r, pins_in.dq})
                {15'h1, 8'h01, 15'h2, 8'h02, 15'h3, 8'h03}: begin
                    load_r <= 1'b1;
                    ld_r <= 64'h0;
                    cnt_r <= 0;
                end
                {15'h1, 8'h11, 15'h2, 8'h12, 15'h3, 8'h13}: id_r <= 1'b1;
                {15'h1, 8'h21, 15'h2, 8'h22, 15'h3, 8'h23}: id_r <= 1'b0;
                default: ;
            endcase
        end
        if (!pwr_n_in) begin
            id_r <= 1'b0;
            load_r <= 1'b0;
            busy_r <= 1'b0;
            tog_r <= 1'b0;
        end
    end
endmodule

/* testbench.sv */
// self-checking bench: sector flash host against a device model
// assumes package, host, model and checker files compile first
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLC = 200;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    logic mclk, rst_n, cmd_valid, cmd_ready, wdat_valid, wdat_ready, rsp_valid, done, err, f_oe;
    logic [7:0] wdat, rsp_data, dq_w, dq_last, f_dq;
    flash_host_pkg::cmd_s cmd;
    flash_host_pkg::pins_s pins;
    int n_fail = 0;
    int cmp_count = 0;
    flash_write_host #(.BLC_LIMIT(BLC), .WC_LIMIT(2000)) i_flash_write_host (
        .mclk_in(mclk), .rst_n_in(rst_n), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
        .wdat_valid_in(wdat_valid), .wdat_in(wdat), .wdat_ready_out(wdat_ready), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .done_out(done), .err_out(err), .flash_out(pins), .dq_in(dq_w));
    flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_flash_dev_model (
        .clk_in(mclk), .pwr_n_in(rst_n), .pins_in(pins), .dq_out(f_dq), .dq_oe_out(f_oe));
    // released wire shows a changing pattern, never a stale byte
    assign dq_w = f_oe ? f_dq : pins.dq_oe ? pins.dq : ~dq_last;
    always @(posedge mclk) dq_last <= dq_w;
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one command with nb sector bytes, byte i being i xor seed
    task automatic run(input flash_host_pkg::op_e op, input logic [14:0] a, input int nb, input logic [7:0] seed);
        int n;
        n = 0;
        @(negedge mclk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        cmd = '{op: op, addr: a};
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (int i = 0; i < nb; i++) begin
            n = 0;
            while (wdat_ready !== 1'b1 && n < 2 * BLC) begin
                @(negedge mclk);
                n++;
            end
            wdat = 8'(i) ^ seed;
            wdat_valid = 1'b1;
            @(negedge mclk);
            wdat_valid = 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        check({7'h00, done}, 8'h01);
        // response strobe stands with done, and only for reads
        check({7'h00, rsp_valid}, {7'h00, op == flash_host_pkg::OP_READ});
    endtask
    task automatic sc_sector(input logic [8:0] s, input logic [7:0] seed);
        run(flash_host_pkg::OP_WRITE, {s, 6'h00}, 64, seed);
        check({7'h00, err}, 8'h00);
        run(flash_host_pkg::OP_READ, {s, 6'h00}, 0, 8'h00);
        check(rsp_data, seed);
        run(flash_host_pkg::OP_READ, {s, 6'h3F}, 0, 8'h00);
        check(rsp_data, 8'h3F ^ seed);
    endtask
    task automatic sc_partial;
        run(flash_host_pkg::OP_WRITE, 15'h0180, 10, 8'h77);
        check({7'h00, err}, 8'h01);
        run(flash_host_pkg::OP_READ, 15'h0183, 0, 8'h00);
        check(rsp_data, 8'h74);
    endtask
    task automatic sc_id;
        run(flash_host_pkg::OP_ID_ENTRY, 15'h0000, 0, 8'h00);
        run(flash_host_pkg::OP_READ, 15'h0000, 0, 8'h00);
        check(rsp_data, MAKER);
        run(flash_host_pkg::OP_READ, 15'h0001, 0, 8'h00);
        check(rsp_data, PART);
        rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        run(flash_host_pkg::OP_READ, 15'h0001, 0, 8'h00);
        check(rsp_data, 8'hFF);
        run(flash_host_pkg::OP_ID_ENTRY, 15'h0000, 0, 8'h00);
        run(flash_host_pkg::OP_ID_EXIT, 15'h0000, 0, 8'h00);
        run(flash_host_pkg::OP_READ, 15'h0000, 0, 8'h00);
        check(rsp_data, 8'hFF);
    endtask
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        wdat_valid = 1'b0;
        wdat = 8'h00;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        sc_sector(9'h005, 8'hA5);
        sc_sector(9'h005, 8'h3C);
        sc_sector(9'h1FF, 8'h00);
        sc_partial;
        sc_id;
        give_verdict;
    end
    // about three and a half times the expected run length
    initial begin
        #400000;
        n_fail++;
        give_verdict;
    end
endmodule
bind flash_write_host flash_write_host_props #(.BLC_LIMIT(BLC_LIMIT)) i_flash_write_host_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .wdat_valid_in(wdat_valid_in), .wdat_in(wdat_in),
    .wdat_ready_out(wdat_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .done_out(done_out), .err_out(err_out), .flash_out(flash_out), .dq_in(dq_in));
